// >>> agiod_top.sv
// Address generation, memory/I-O cycle steering and configuration port decode
// Summary of operation
// [R1] Narrow variant keeps physical memory addresses within a 24-bit, 16-megabyte range.
// [R2] Wide variant drives physical memory addresses across the full 32-bit range.
// [R3] I/O space is 64 kilobytes, reached with byte, word or dword transfers.
// [R4] Coprocessor opcodes access an eight-port window in upper I/O space.
// [R5] Port input and output cycles drive the memory/I-O select low.
// [R6] Port accesses drive the upper eight address lines to zero.
// [R7] Index written to config_index_port, then data moved through config_data_port.
// [R8] Hits on on-chip configuration registers finish internally, no external cycle.
// [R9] Data-port access without fresh index write goes off-chip, registers unchanged.
// [R10] Index write outside C0h..CFh goes off-chip and arms nothing.
// [R11] Reads of the index port always go to the external bus.
// [R12] Multi-byte operands are little-endian, addressed by their lowest byte.
// [R13] Effective address sums optional base from eight registers, scaled index, displacement.
// [R14] Index from any register but the stack pointer, scaled by 1, 2, 4, 8.
// [R15] Displacement of up to 32 bits is the third addend.
// [R16] Exactly nine operand forms are accepted; others fault.
// [R17] Real mode address is segment shifted left four plus 16-bit offset.
// [R18] Real mode 21-bit sum, carry included, is zero-extended to the bus width.
// [R19] Real mode access beyond one megabyte raises segment limit overrun.
// [R20] Real mode carry is kept as a twenty-first address bit.
// [R21] Effective address summation wraps modulo two to the thirty-second.
`timescale 1ns/10ps
module agiod_top
  import agiod_pkg::*;
#(
  parameter bit WIDE_BUS = 1'b1
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  input  wire agiod_op_e   req_op,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_size,
  input  wire logic [31:0] req_wdata,
  input  wire logic [15:0] req_port,
  input  wire logic        req_real_mode,
  input  wire logic        req_limit_check,
  input  wire logic [15:0] req_segment,
  input  wire logic [31:0] req_base_val,
  input  wire logic [31:0] req_index_val,
  input  wire logic [2:0]  req_index_sel,
  input  wire logic [1:0]  req_scale,
  input  wire logic [31:0] req_disp,
  input  wire logic        req_has_base,
  input  wire logic        req_has_index,
  input  wire logic        req_has_disp,
  output logic             req_ready,
  output logic             rsp_done,
  output logic [31:0]      rsp_rdata,
  output logic             rsp_limit_fault,
  output logic             rsp_form_fault,
  output logic             ext_start,
  output logic [31:0]      ext_addr,
  output logic             ext_mem_sel,
  output logic             ext_write,
  output logic [3:0]       ext_byte_en,
  output logic [31:0]      ext_wdata,
  input  wire logic        ext_done,
  input  wire logic [31:0] ext_rdata
);

  typedef enum logic [0:0] {
    AGIOD_IDLE,
    AGIOD_WAIT
  } agiod_state_e;

  agiod_ea_if ea_bus ();

  agiod_ea_unit u_ea (
    .ea_bus (ea_bus)
  );

  assign ea_bus.base_val  = req_base_val;
  assign ea_bus.index_val = req_index_val;
  assign ea_bus.index_sel = req_index_sel;
  assign ea_bus.scale     = req_scale;
  assign ea_bus.disp      = req_disp;
  assign ea_bus.has_base  = req_has_base;
  assign ea_bus.has_index = req_has_index;
  assign ea_bus.has_disp  = req_has_disp;

  agiod_state_e state_ff;
  logic         ready_ff;
  logic         done_ff;
  logic [31:0]  rdata_ff;
  logic         limit_fault_ff;
  logic         form_fault_ff;
  logic         start_ff;
  logic [31:0]  addr_ff;
  logic         mem_sel_ff;
  logic         write_ff;
  logic [3:0]   byte_en_ff;
  logic [31:0]  wdata_ff;
  logic         armed_ff;
  logic [3:0]   arm_idx_ff;
  logic [7:0]   cfg_mem [CFG_REG_COUNT];
  logic         done_meta_ff;
  logic         done_sync_ff;
  logic         done_prev_ff;
  logic [31:0]  rdata_meta_ff;
  logic [31:0]  rdata_sync_ff;

  logic         take;
  logic [20:0]  real_sum;
  logic [31:0]  nxt_addr;
  logic         nxt_mem_sel;
  logic [3:0]   size_be;
  logic         idx_in_range;
  logic         hit_index_wr;
  logic         hit_data;
  logic         go_internal;
  logic         limit_err;
  logic         form_err;
  logic         ext_finish;

  assign take = req_valid && ready_ff && state_ff == AGIOD_IDLE;

  // Segment shifted four places plus offset; the 21-bit width keeps the carry
  assign real_sum = {1'b0, req_segment, REAL_SHIFT_ZEROS}
                  + {5'h00, ea_bus.ea[15:0]}; // [R17] [R20]

  always_comb
  begin
    nxt_addr    = 32'h0000_0000;
    nxt_mem_sel = 1'b1;
    if (req_op == AGIOD_OP_IO)
    begin
      nxt_addr    = {16'h0000, req_port}; // [R3] [R6]
      nxt_mem_sel = 1'b0; // [R5]
    end
    else if (req_op == AGIOD_OP_COPRO)
    begin
      nxt_addr    = (WIDE_BUS ? COPRO_BASE_WIDE : COPRO_BASE_NARROW)
                  | {29'h0000_0000, req_port[2:0]}; // [R4]
      nxt_mem_sel = 1'b0;
    end
    else if (req_real_mode)
    begin
      nxt_addr = {11'h000, real_sum}; // [R18]
    end
    else
    begin
      nxt_addr = ea_bus.ea & (WIDE_BUS ? PHYS_MASK_WIDE : PHYS_MASK_NARROW); // [R1] [R2]
    end
  end

  always_comb
  begin
    if (req_size == SIZE_BYTE)
      size_be = BE_BYTE;
    else if (req_size == SIZE_WORD)
      size_be = BE_WORD;
    else
      size_be = BE_DWORD;
  end

  assign idx_in_range = req_wdata[7:0] >= CFG_INDEX_FIRST
                     && req_wdata[7:0] <= CFG_INDEX_LAST; // [R10]
  // Reads of the index port never qualify, so they always fall through to the bus
  assign hit_index_wr = req_op == AGIOD_OP_IO && req_port == CFG_INDEX_PORT
                     && req_write && idx_in_range; // [R11] [R7]
  assign hit_data     = req_op == AGIOD_OP_IO && req_port == CFG_DATA_PORT && armed_ff; // [R9]
  assign go_internal  = hit_index_wr || hit_data; // [R8]
  assign limit_err    = req_op == AGIOD_OP_MEM && req_real_mode && req_limit_check
                     && real_sum[REAL_TOP_BIT]; // [R19]
  assign form_err     = req_op == AGIOD_OP_MEM && !ea_bus.form_ok; // [R16]
  assign ext_finish   = state_ff == AGIOD_WAIT && done_sync_ff && !done_prev_ff;

  // Bus handshake and read data come from pins, so both are synchronised first
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      done_meta_ff  <= 1'b0;
      done_sync_ff  <= 1'b0;
      done_prev_ff  <= 1'b0;
      rdata_meta_ff <= 32'h0000_0000;
      rdata_sync_ff <= 32'h0000_0000;
    end
    else
    begin
      done_meta_ff  <= ext_done;
      done_sync_ff  <= done_meta_ff;
      done_prev_ff  <= done_sync_ff;
      rdata_meta_ff <= ext_rdata;
      rdata_sync_ff <= rdata_meta_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff <= AGIOD_IDLE;
      ready_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        AGIOD_IDLE:
        begin
          ready_ff <= 1'b1;
          if (take && !go_internal && !limit_err && !form_err)
          begin
            state_ff <= AGIOD_WAIT;
            ready_ff <= 1'b0;
          end
        end
        AGIOD_WAIT:
        begin
          if (ext_finish)
          begin
            state_ff <= AGIOD_IDLE;
            ready_ff <= 1'b1;
          end
        end
        default:
        begin
          state_ff <= AGIOD_IDLE;
        end
      endcase
    end
  end

  // External cycle launch; byte lanes follow the low address bits, lowest byte first
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_ff   <= 1'b0;
      addr_ff    <= 32'h0000_0000;
      mem_sel_ff <= 1'b1;
      write_ff   <= 1'b0;
      byte_en_ff <= 4'h0;
      wdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      start_ff <= take && !go_internal && !limit_err && !form_err;
      if (take && !go_internal && !limit_err && !form_err)
      begin
        addr_ff    <= nxt_addr;
        mem_sel_ff <= nxt_mem_sel;
        write_ff   <= req_write;
        // Operands crossing a dword boundary lose their upper lanes; the core must split them
        byte_en_ff <= size_be << nxt_addr[1:0]; // [R12]
        wdata_ff   <= req_wdata << {nxt_addr[1:0], 3'h0}; // [R12]
      end
    end
  end

  // Index arming: one valid index write enables exactly one data-port access
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      armed_ff   <= 1'b0;
      arm_idx_ff <= 4'h0;
    end
    else if (take && req_op == AGIOD_OP_IO && req_port == CFG_INDEX_PORT && req_write)
    begin
      armed_ff   <= idx_in_range; // [R10]
      arm_idx_ff <= req_wdata[3:0]; // [R7]
    end
    else if (take && hit_data)
    begin
      armed_ff <= 1'b0; // [R9]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CFG_REG_COUNT; gi++)
    begin : g_cfg
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          cfg_mem[gi] <= CFG_RESET_VALUE;
        else if (take && hit_data && req_write && arm_idx_ff == 4'(gi))
          cfg_mem[gi] <= req_wdata[7:0]; // [R7]
      end
    end
  endgenerate

  // Answer to the core: internal hits and faults finish in one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      done_ff        <= 1'b0;
      rdata_ff       <= 32'h0000_0000;
      limit_fault_ff <= 1'b0;
      form_fault_ff  <= 1'b0;
    end
    else
    begin
      done_ff        <= (take && (go_internal || limit_err || form_err)) || ext_finish;
      limit_fault_ff <= take && limit_err && !form_err;
      form_fault_ff  <= take && form_err;
      if (take && hit_data && !req_write)
        rdata_ff <= {24'h00_0000, cfg_mem[arm_idx_ff]}; // [R8]
      else if (take)
        rdata_ff <= 32'h0000_0000;
      else if (ext_finish)
        rdata_ff <= write_ff ? 32'h0000_0000
                  : rdata_sync_ff >> {addr_ff[1:0], 3'h0}; // [R12]
    end
  end

  assign req_ready       = ready_ff;
  assign rsp_done        = done_ff;
  assign rsp_rdata       = rdata_ff;
  assign rsp_limit_fault = limit_fault_ff;
  assign rsp_form_fault  = form_fault_ff;
  assign ext_start       = start_ff;
  assign ext_addr        = addr_ff;
  assign ext_mem_sel     = mem_sel_ff;
  assign ext_write       = write_ff;
  assign ext_byte_en     = byte_en_ff;
  assign ext_wdata       = wdata_ff;

endmodule : agiod_top

// >>> agiod_pkg.sv
// Constants and types shared by the address generation and port decode block
package agiod_pkg;

  localparam logic [31:0] PHYS_MASK_NARROW = 32'h00ff_ffff;
  localparam logic [31:0] PHYS_MASK_WIDE   = 32'hffff_ffff;
  localparam logic [31:0] COPRO_BASE_NARROW = 32'h0080_00f8;
  localparam logic [31:0] COPRO_BASE_WIDE   = 32'h8000_00f8;
  localparam logic [15:0] CFG_INDEX_PORT   = 16'h0022;
  localparam logic [15:0] CFG_DATA_PORT    = 16'h0023;
  localparam logic [7:0]  CFG_INDEX_FIRST  = 8'hc0;
  localparam logic [7:0]  CFG_INDEX_LAST   = 8'hcf;
  localparam int          CFG_REG_COUNT    = 16;
  localparam logic [7:0]  CFG_RESET_VALUE  = 8'h00;
  localparam logic [2:0]  STACK_POINTER_SEL = 3'h4;
  localparam logic [3:0]  REAL_SHIFT_ZEROS = 4'h0;
  localparam int          REAL_TOP_BIT     = 20;

  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_WORD  = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  localparam logic [3:0] BE_BYTE    = 4'h1;
  localparam logic [3:0] BE_WORD    = 4'h3;
  localparam logic [3:0] BE_DWORD   = 4'hf;

  typedef enum logic [1:0] {
    AGIOD_OP_MEM,
    AGIOD_OP_IO,
    AGIOD_OP_COPRO
  } agiod_op_e;

endpackage : agiod_pkg

// >>> agiod_ea_if.sv
// Operand fields and effective address between the decode top and the address adder
`timescale 1ns/10ps
interface agiod_ea_if;
  logic [31:0] base_val;
  logic [31:0] index_val;
  logic [2:0]  index_sel;
  logic [1:0]  scale;
  logic [31:0] disp;
  logic        has_base;
  logic        has_index;
  logic        has_disp;
  logic [31:0] ea;
  logic        form_ok;

  modport core (output base_val, index_val, index_sel, scale, disp,
                output has_base, has_index, has_disp,
                input  ea, form_ok);
  modport unit (input  base_val, index_val, index_sel, scale, disp,
                input  has_base, has_index, has_disp,
                output ea, form_ok);
endinterface : agiod_ea_if

// >>> agiod_ea_unit.sv
// Effective address adder: base plus scaled index plus displacement
`timescale 1ns/10ps
module agiod_ea_unit
  import agiod_pkg::*;
(
  agiod_ea_if.unit ea_bus
);

  logic [31:0] base_term;
  logic [31:0] index_term;
  logic [31:0] disp_term;

  always_comb
  begin
    base_term  = ea_bus.has_base ? ea_bus.base_val : 32'h0000_0000; // [R13]
    // Scale is a shift of 0..3, so the scaled index wraps at 32 bits like the sum
    index_term = ea_bus.has_index ? (ea_bus.index_val << ea_bus.scale) : 32'h0000_0000; // [R14]
    disp_term  = ea_bus.has_disp ? ea_bus.disp : 32'h0000_0000; // [R15]
  end

  // Carry past bit 31 is dropped by the 32-bit result width
  assign ea_bus.ea = base_term + index_term + disp_term; // [R21]

  // Only the nine legal operand forms; an index never comes alone, never from the stack pointer
  assign ea_bus.form_ok = (ea_bus.has_base || ea_bus.has_disp)
                       && !(ea_bus.has_index && ea_bus.index_sel == STACK_POINTER_SEL)
                       && (ea_bus.has_index || ea_bus.scale == 2'h0); // [R16] [R14]

endmodule : agiod_ea_unit

// >>> agiod_top_asserts.sv
// Assertions on the ports of the address generation and port decode top
`timescale 1ns/10ps
module agiod_top_asserts
  import agiod_pkg::*;
#(
  parameter bit WIDE_BUS = 1'b1
)
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire agiod_op_e   req_op,
  input wire logic        req_write,
  input wire logic [31:0] req_wdata,
  input wire logic [15:0] req_port,
  input wire logic        req_has_index,
  input wire logic [2:0]  req_index_sel,
  input wire logic        rsp_done,
  input wire logic        rsp_form_fault,
  input wire logic        rsp_limit_fault,
  input wire logic        ext_start,
  input wire logic [31:0] ext_addr,
  input wire logic        ext_mem_sel,
  input wire logic        ext_done
);
  localparam logic [31:0] CB = WIDE_BUS ? COPRO_BASE_WIDE : COPRO_BASE_NARROW;
  wire take   = req_valid && req_ready;
  wire io_in  = take && req_op == AGIOD_OP_IO;
  wire io_wr  = io_in && req_write && req_port == CFG_INDEX_PORT;
  wire idx_ok = req_wdata[7:0] >= CFG_INDEX_FIRST && req_wdata[7:0] <= CFG_INDEX_LAST;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_io_upper_zero: assert property (
    io_in |=> !ext_start || (!ext_mem_sel && ext_addr[31:24] == 8'h00))
    else $error("port cycle with memory select or upper address bits");
  chk_copro_window: assert property (
    take && req_op == AGIOD_OP_COPRO |=> ext_start && !ext_mem_sel
      && ext_addr == (CB | {29'h0, $past(req_port[2:0])}))
    else $error("coprocessor cycle outside its port window");
  chk_narrow_range: assert property (
    ext_start && ext_mem_sel |-> WIDE_BUS || ext_addr[31:24] == 8'h00)
    else $error("narrow memory address above 24 bits");
  chk_cfg_internal: assert property (
    io_wr && idx_ok |=> rsp_done && !ext_start)
    else $error("valid index write did not finish internally");
  chk_bad_index: assert property (
    io_wr && !idx_ok |=> ext_start)
    else $error("out of range index write stayed on chip");
  chk_index_read: assert property (
    io_in && !req_write && req_port == CFG_INDEX_PORT |=> ext_start)
    else $error("index port read stayed on chip");
  chk_stack_index: assert property (
    take && req_op == AGIOD_OP_MEM && req_has_index && req_index_sel == STACK_POINTER_SEL
      |=> rsp_form_fault && !ext_start)
    else $error("stack pointer index accepted");
  chk_fault_quiet: assert property (
    rsp_form_fault || rsp_limit_fault |-> rsp_done && !ext_start)
    else $error("fault without done or with a bus cycle");
  chk_bus_finish: assert property (
    $rose(ext_done) |-> ##[1:4] rsp_done)
    else $error("bus answer not completed in time");
  cover property (take && req_op == AGIOD_OP_COPRO);
  cover property (rsp_limit_fault);
  cover property (io_in && req_port == CFG_DATA_PORT);
endmodule : agiod_top_asserts

bind agiod_top agiod_top_asserts #(.WIDE_BUS(WIDE_BUS)) chk_u (.clk, .rst_n, .req_valid,
  .req_ready, .req_op, .req_write, .req_wdata, .req_port, .req_has_index, .req_index_sel,
  .rsp_done, .rsp_form_fault, .rsp_limit_fault, .ext_start, .ext_addr, .ext_mem_sel, .ext_done);

// >>> agiod_bus_model.sv
// External bus with memory and port devices answering every started cycle
`timescale 1ns/10ps
module agiod_bus_model
(
  input  wire logic        clk,
  input  wire logic        ext_start,
  input  wire logic [31:0] ext_addr,
  input  wire logic [3:0]  wait_cycles,
  output logic             ext_done,
  output logic [31:0]      ext_rdata,
  output int               start_count
);
  initial
  begin
    ext_done    = 1'b0;
    ext_rdata   = 32'h0000_0000;
    start_count = 0;
    forever
    begin
      // Launch pulse is looked at half a clock after the edge that raised it
      @(negedge clk);
      if (ext_start === 1'b1)
      begin
        start_count++;
        ext_rdata = ext_addr ^ 32'ha5a5_0f0f;
        // Data leads done by two clocks plus wait_cycles so it clears the synchronisers
        repeat (2 + wait_cycles) @(negedge clk);
        ext_done = 1'b1;
        repeat (3) @(negedge clk);
        ext_done = 1'b0;
        ext_rdata = ~ext_rdata;
      end
    end
  end
endmodule : agiod_bus_model

// >>> agiod_top_tb.sv
// Self-checking bench for the address generation and port decode block
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module agiod_top_tb
  import agiod_pkg::*;
();
  localparam bit          W    = 1'b0;
  localparam logic [31:0] MASK = W ? PHYS_MASK_WIDE : PHYS_MASK_NARROW;
  localparam logic [31:0] CB   = W ? COPRO_BASE_WIDE : COPRO_BASE_NARROW;
  localparam logic [31:0] KEY  = 32'ha5a5_0f0f;
  // Digits: external count, write, port, data
  localparam logic [23:0] SEQ [9] = '{24'h0122c3, 24'h01235a, 24'h112311, 24'h0122c3,
    24'h002300, 24'h102300, 24'h1122d0, 24'h102300, 24'h102200};
  localparam logic [3:0]  FORMS [9] = '{4'h2, 4'h8, 4'ha, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
  logic        clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic        req_real_mode = 1'b0, req_limit_check = 1'b0;
  logic        req_has_base = 1'b0, req_has_index = 1'b0, req_has_disp = 1'b1;
  logic        req_ready, rsp_done, rsp_limit_fault, rsp_form_fault;
  logic        ext_start, ext_mem_sel, ext_write, ext_done;
  agiod_op_e   req_op = AGIOD_OP_IO;
  logic [1:0]  req_size = SIZE_DWORD, req_scale = 2'h0;
  logic [2:0]  req_index_sel = 3'h1;
  logic [3:0]  ext_byte_en, wait_cycles = 4'h5;
  logic [15:0] req_port = 16'h0000, req_segment = 16'h0000;
  logic [31:0] req_wdata = 32'h0, req_base_val = 32'hf000_0011, req_index_val = 32'h1000_0100;
  logic [31:0] req_disp = 32'h0000_2002, rsp_rdata, ext_addr, ext_wdata, ext_rdata, ea;
  int          bad_count = 0, check_count = 0, starts, n0 = 0;
  logic [31:0] wide_addr;

  agiod_top #(.WIDE_BUS(W)) dut_u (.clk, .rst_n, .req_valid, .req_op, .req_write, .req_size,
    .req_wdata, .req_port, .req_real_mode, .req_limit_check, .req_segment, .req_base_val,
    .req_index_val, .req_index_sel, .req_scale, .req_disp, .req_has_base, .req_has_index,
    .req_has_disp, .req_ready, .rsp_done, .rsp_rdata, .rsp_limit_fault, .rsp_form_fault,
    .ext_start, .ext_addr, .ext_mem_sel, .ext_write, .ext_byte_en, .ext_wdata, .ext_done,
    .ext_rdata);
  agiod_bus_model bus_u (.clk, .ext_start, .ext_addr, .wait_cycles, .ext_done, .ext_rdata,
    .start_count(starts));
  // Wide variant runs in lockstep on the same requests and bus answers
  agiod_top #(.WIDE_BUS(1'b1)) dut_wide_u (.clk, .rst_n, .req_valid, .req_op, .req_write,
    .req_size, .req_wdata, .req_port, .req_real_mode, .req_limit_check, .req_segment,
    .req_base_val, .req_index_val, .req_index_sel, .req_scale, .req_disp, .req_has_base,
    .req_has_index, .req_has_disp, .req_ready(), .rsp_done(), .rsp_rdata(),
    .rsp_limit_fault(), .rsp_form_fault(), .ext_start(), .ext_addr(wide_addr),
    .ext_mem_sel(), .ext_write(), .ext_byte_en(), .ext_wdata(), .ext_done, .ext_rdata);

  initial
  begin
    forever
      #25 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // One request at a time: no queue behind the ready flag
  task automatic run(input agiod_op_e op, input logic wr, input logic [15:0] port,
                     input logic [31:0] wd);
    int n;
    // Let an edge pass so valid is never lowered and raised in one time step
    @(negedge clk);
    n         = 0;
    n0        = starts;
    req_op    = op;
    req_write = wr;
    req_port  = port;
    req_wdata = wd;
    while (req_ready !== 1'b1 && n < 30)
    begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_done !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("done", 1'b1, rsp_done)
    `CHK("ready", 1'b1, req_ready)
  endtask : run

  task automatic ext(input int cnt, input logic [31:0] a, input logic sel, input logic [3:0] be);
    `CHK("ext_cnt", cnt, starts - n0)
    `CHK("ext_addr", a, ext_addr)
    `CHK("ext_sel", sel, ext_mem_sel)
    `CHK("ext_be", be, ext_byte_en)
  endtask : ext

  initial
  begin
    #(3000 * 50);
    bad_count++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    run(AGIOD_OP_IO, 1'b0, 16'h0060, 32'h0);
    ext(1, 32'h0000_0060, 1'b0, BE_DWORD);
    `CHK("io_rd", 32'h0000_0060 ^ KEY, rsp_rdata)
    wait_cycles = 4'h0;
    req_size = SIZE_BYTE;
    run(AGIOD_OP_IO, 1'b1, 16'hfffd, 32'h0000_0077);
    ext(1, 32'h0000_fffd, 1'b0, 4'h2);
    `CHK("io_wd", 32'h0000_7700, ext_wdata)
    req_size = SIZE_DWORD;
    for (int i = 0; i < 9; i++)
    begin
      run(AGIOD_OP_IO, SEQ[i][16], {8'h00, SEQ[i][15:8]}, {24'h0, SEQ[i][7:0]});
      `CHK("cfg_ext", int'(SEQ[i][20]), starts - n0)
      if (i == 4)
        `CHK("cfg_rd", 32'h0000_005a, rsp_rdata)
    end
    run(AGIOD_OP_COPRO, 1'b0, 16'h0004, 32'h0);
    ext(1, CB | 32'h4, 1'b0, BE_DWORD);
    `CHK("wide_copro", COPRO_BASE_WIDE | 32'h4, wide_addr)
    for (int i = 0; i < 9; i++)
    begin
      {req_has_base, req_has_index, req_has_disp} = FORMS[i][3:1];
      req_scale = {FORMS[i][0], 1'b0};
      ea = (req_has_base ? req_base_val : 32'h0) + (req_has_disp ? req_disp : 32'h0)
           + (req_has_index ? req_index_val << req_scale : 32'h0);
      run(AGIOD_OP_MEM, 1'b0, 16'h0, 32'h0);
      ext(1, ea & MASK, 1'b1, BE_DWORD << ea[1:0]);
      `CHK("wide_addr", ea, wide_addr)
    end
    req_index_sel = STACK_POINTER_SEL;
    run(AGIOD_OP_MEM, 1'b0, 16'h0, 32'h0);
    `CHK("sp_form", 1'b1, rsp_form_fault)
    req_index_sel = 3'h1;
    {req_has_base, req_has_disp} = 2'b00;
    run(AGIOD_OP_MEM, 1'b0, 16'h0, 32'h0);
    `CHK("no_form", 1'b1, rsp_form_fault)
    {req_has_index, req_has_disp, req_scale, req_size} = {1'b0, 1'b1, 2'h0, SIZE_WORD};
    req_disp = 32'h0000_1001;
    run(AGIOD_OP_MEM, 1'b1, 16'h0, 32'h0000_beef);
    ext(1, 32'h0000_1001, 1'b1, 4'h6);
    `CHK("mem_wd", 32'h00be_ef00, ext_wdata)
    `CHK("mem_wr", 1'b1, ext_write)
    req_size = SIZE_DWORD;
    req_real_mode = 1'b1;
    req_segment = 16'h1234;
    req_disp = 32'h0000_5678;
    run(AGIOD_OP_MEM, 1'b0, 16'h0, 32'h0);
    ext(1, 32'h0001_79b8, 1'b1, BE_DWORD);
    `CHK("wide_real", 32'h0001_79b8, wide_addr)
    req_segment = 16'hffff;
    req_disp = 32'h0000_0010;
    run(AGIOD_OP_MEM, 1'b0, 16'h0, 32'h0);
    ext(1, 32'h0010_0000, 1'b1, BE_DWORD);
    `CHK("wide_carry", 32'h0010_0000, wide_addr)
    req_limit_check = 1'b1;
    run(AGIOD_OP_MEM, 1'b0, 16'h0, 32'h0);
    `CHK("limit", 1'b1, rsp_limit_fault)
    `CHK("lim_ext", 0, starts - n0)
    finish_test();
  end
endmodule : agiod_top_tb
